// ==== include/ext_bus_defs.svh ====
// timing counts and strap encodings for the external bus strobe block
`ifndef EXT_BUS_DEFS_SVH
`define EXT_BUS_DEFS_SVH
`define BCLK_DIV        4'h2
`define WIDTH_STRAP_16  1'h0
`define SCHEME_SPLIT    1'h0
`define SCHEME_COMBINED 1'h1
`endif

// ==== include/ext_bus_pkg.sv ====
// types shared by the external bus strobe block
package ext_bus_pkg;
  typedef struct packed {
    logic        write;
    logic [19:0] addr;
    logic [1:0]  space;
    logic [15:0] wdata;
  } bus_req_t;
  typedef struct packed {
    logic read_n;
    logic store_even_n;
    logic store_odd_n;
    logic ale;
  } strobes_t;
endpackage : ext_bus_pkg

// ==== design/external_bus_strobe_control.sv ====
// external bus strobe sequencer with hold, ready and write-strobe schemes
//
// Contract
// - split scheme, 16-bit bus: even store low for even, odd store for odd.
// - read strobe driven low during read; external data valid meanwhile.
// - combined scheme: single store strobe, upper byte enable low on odd address.
// - software selects split or combined scheme with scheme_i; combined uses upper_byte_enable_n_o, not the odd store.
// - bus request low puts block into hold, releasing the bus.
// - grant output low for the whole hold state only.
// - address latch strobe given each access for external address capture.
// - ready low stretches the current access until it returns high.
// - multiplexed bus: address then data on shared pins, separate phases.
// - four active-low space selects name the accessed space.
`timescale 1ns/100ps
`include "ext_bus_defs.svh"
module external_bus_strobe_control
(
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 nrst_i,
  // configuration
  input  wire logic                 scheme_i,
  input  wire logic                 width_strap_i,
  // access request from the core
  input  wire logic                 req_valid_i,
  input  wire ext_bus_pkg::bus_req_t req_i,
  output logic                      req_ready_o,
  output logic                      done_o,
  output logic [15:0]               rdata_o,
  // external bus pins
  input  wire logic                 bus_request_n_i,
  input  wire logic                 ready_i,
  output logic                      bus_grant_n_o,
  output logic                      bclk_o,
  output ext_bus_pkg::strobes_t     strobes_o,
  output logic                      upper_byte_enable_n_o,
  output logic [3:0]                space_select_n_o,
  output logic [19:0]               addr_o,
  input  wire logic [15:0]          ad_i,
  output logic [15:0]               ad_o,
  output logic                      ad_oe_o
);
  typedef enum logic [2:0] {IDLE, ADDR, DATA, WAITRDY, HOLD} state_t;
  state_t                state_reg;
  ext_bus_pkg::bus_req_t cur_reg;
  logic [3:0]            div_reg;
  logic                  tick;
  logic                  is_16;
  logic                  odd;

  assign is_16 = (width_strap_i == `WIDTH_STRAP_16);
  assign odd   = cur_reg.addr[0];
  assign tick  = (div_reg == `BCLK_DIV - 4'h1);

  // bus clock divider; phases advance on one-cycle ticks
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      div_reg <= 4'h0;
      bclk_o  <= 1'b0;
    end
    else
    begin
      div_reg <= tick ? 4'h0 : div_reg + 4'h1;
      if (tick)
        bclk_o <= ~bclk_o;
    end
  end

  // access sequencer; hold only taken between accesses to avoid tearing one
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_reg <= IDLE;
      cur_reg   <= '0;
    end
    else if (tick)
    begin
      case (state_reg)
        IDLE:
        begin
          if (!bus_request_n_i)
            state_reg <= HOLD;
          else if (req_valid_i)
          begin
            cur_reg   <= req_i;
            state_reg <= ADDR;
          end
        end
        ADDR:    state_reg <= DATA;
        DATA:    state_reg <= ready_i ? IDLE : WAITRDY;
        WAITRDY: state_reg <= ready_i ? IDLE : WAITRDY;
        HOLD:    state_reg <= bus_request_n_i ? IDLE : HOLD;
        default: state_reg <= IDLE;
      endcase
    end
  end

  // core handshake: accept in idle, pulse done at end of access
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      req_ready_o <= 1'b0;
      done_o      <= 1'b0;
      rdata_o     <= 16'h0000;
    end
    else
    begin
      req_ready_o <= 1'b0;
      done_o      <= 1'b0;
      if (tick && state_reg == IDLE && bus_request_n_i && req_valid_i)
        req_ready_o <= 1'b1;
      if (tick && (state_reg == DATA || state_reg == WAITRDY) && ready_i)
      begin
        done_o <= 1'b1;
        if (!cur_reg.write)
          rdata_o <= ad_i; // sampled while read strobe is low
      end
    end
  end

  // pin drivers, all registered from the current state register, so they lag the state by one clock
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      strobes_o             <= '{1'b1, 1'b1, 1'b1, 1'b0};
      upper_byte_enable_n_o <= 1'b1;
      bus_grant_n_o         <= 1'b1;
      space_select_n_o      <= 4'hF;
      addr_o                <= 20'h00000;
      ad_o                  <= 16'h0000;
      ad_oe_o               <= 1'b0;
    end
    else
    begin
      bus_grant_n_o <= (state_reg != HOLD);
      // read and store strobes idle high outside data phases, address latch strobe low outside the address phase
      strobes_o <= '{1'b1, 1'b1, 1'b1, 1'b0};
      upper_byte_enable_n_o <= 1'b1;
      space_select_n_o <= 4'hF;
      ad_oe_o <= 1'b0;
      if (state_reg == ADDR || state_reg == DATA || state_reg == WAITRDY)
      begin
        space_select_n_o <= ~(4'h1 << cur_reg.space);
        addr_o           <= cur_reg.addr;
      end
      if (state_reg == ADDR)
      begin
        strobes_o.ale <= 1'b1;
        ad_o          <= cur_reg.addr[15:0];
        ad_oe_o       <= 1'b1;
      end
      if (state_reg == DATA || state_reg == WAITRDY)
      begin
        ad_o    <= cur_reg.wdata;
        ad_oe_o <= cur_reg.write;
        if (!cur_reg.write)
          strobes_o.read_n <= 1'b0;
        else if (scheme_i == `SCHEME_SPLIT && is_16)
        begin
          strobes_o.store_even_n <= odd;
          strobes_o.store_odd_n  <= ~odd;
        end
        else
          strobes_o.store_even_n <= 1'b0;
        // combined scheme and the 8-bit split bus leave the odd store strobe high as set above
        if (scheme_i == `SCHEME_COMBINED)
          upper_byte_enable_n_o <= ~odd;
      end
    end
  end

  // in combined mode pin_odd_or_ube carries the upper byte enable; it drives no output, store_odd_n stays high
  logic pin_odd_or_ube;
  assign pin_odd_or_ube = (scheme_i == `SCHEME_COMBINED)
                          ? upper_byte_enable_n_o : strobes_o.store_odd_n;

  a_grant_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state_reg == HOLD |=> !bus_grant_n_o) else $error("grant not low in hold");
  a_idle_strobe: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $past(state_reg) == IDLE |-> strobes_o.read_n && strobes_o.store_even_n)
    else $error("strobe active while idle");
  a_hold_entry: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tick && state_reg == IDLE && !bus_request_n_i |=> state_reg == HOLD)
    else $error("hold not entered");
  a_ready_wait: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tick && state_reg == WAITRDY && !ready_i |=> state_reg == WAITRDY)
    else $error("wait left while not ready");
  a_ale_addr: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state_reg == ADDR |=> strobes_o.ale && ad_oe_o)
    else $error("no address latch in address phase");
  a_read_low: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state_reg == DATA && !cur_reg.write |=> !strobes_o.read_n)
    else $error("read strobe missing");
  a_split_even: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state_reg == DATA && cur_reg.write && !scheme_i && is_16 && !odd
    |=> !strobes_o.store_even_n && strobes_o.store_odd_n)
    else $error("even store wrong");
  a_ube_odd: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state_reg == DATA && scheme_i && odd |=> !upper_byte_enable_n_o)
    else $error("upper byte enable wrong");

  // access steps: address phase ends on a tick, data phase follows
  sequence s_addr_end;
    tick && state_reg == ADDR;
  endsequence
  sequence s_data_start;
    state_reg == DATA;
  endsequence

  a_phase_order: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_addr_end |=> s_data_start)
    else $error("data phase does not follow address");
  a_split_odd: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state_reg == DATA && cur_reg.write && !scheme_i && is_16 && odd
    |=> !strobes_o.store_odd_n && strobes_o.store_even_n)
    else $error("odd store wrong");
  a_shared_pin: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state_reg == DATA && cur_reg.write && scheme_i && odd
    |=> !pin_odd_or_ube)
    else $error("shared pin not low");
  a_data_drive: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state_reg == DATA && cur_reg.write |=> ad_oe_o && ad_o == cur_reg.wdata)
    else $error("write data not driven");
  a_space_sel: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state_reg == ADDR |=> space_select_n_o == ~(4'h1 << cur_reg.space))
    else $error("space select wrong");
endmodule : external_bus_strobe_control

// ==== verification/ext_mem_model.sv ====
// peripheral model: read data and ready wait states
`timescale 1ns/100ps
module ext_mem_model
(
  // bus side
  input  wire logic                  clk_i,
  input  wire ext_bus_pkg::strobes_t strobes_i,
  input  wire logic [19:0]           addr_i,
  input  wire logic [3:0]            waits_i,
  output logic                       ready_o,
  output logic [15:0]                ad_o
);
  int cnt = 0;
  logic [15:0] junk = 16'h0000;
  // count cycles of an active strobe; ready stays low for waits_i
  always @(posedge clk_i)
    cnt <= (&strobes_i[3:1]) ? 0 : cnt + 1;
  assign ready_o = (cnt >= waits_i);
  // data shown at once while read strobe low, so the end-of-phase
  // sample sees it; otherwise a toggling pattern
  always @(posedge clk_i)
    junk <= ~junk;
  assign ad_o = !strobes_i.read_n ? addr_i[15:0] ^ 16'h5A5A : junk;
endmodule : ext_mem_model

// ==== verification/external_bus_strobe_control_tb_top.sv ====
// testbench: random accesses checked against expected strobes and read data
`timescale 1ns/100ps
module external_bus_strobe_control_tb_top;
  logic clk_i = 0, nrst_i = 0, scheme_i = 0, width_strap_i = 0;
  logic req_valid_i = 0, bus_request_n_i = 1, act = 0;
  ext_bus_pkg::bus_req_t req_i = '0;
  ext_bus_pkg::strobes_t strobes_o;
  logic req_ready_o, done_o, bus_grant_n_o, ready_i, ube;
  logic [15:0] rdata_o, ad_i;
  logic [19:0] addr;
  logic [3:0] waits = 0, sel;
  logic [5:0] seen = 0;
  int failures = 0, checks_done = 0, cyc = 0, lat, lat0;
  wire [2:0] lo = ~strobes_o[3:1];
  always #12.5 clk_i = ~clk_i;
  external_bus_strobe_control external_bus_strobe_control_inst
  (.clk_i(clk_i), .nrst_i(nrst_i), .scheme_i(scheme_i),
   .width_strap_i(width_strap_i), .req_valid_i(req_valid_i), .req_i(req_i),
   .req_ready_o(req_ready_o), .done_o(done_o), .rdata_o(rdata_o),
   .bus_request_n_i(bus_request_n_i), .ready_i(ready_i),
   .bus_grant_n_o(bus_grant_n_o), .bclk_o(), .strobes_o(strobes_o),
   .upper_byte_enable_n_o(ube), .space_select_n_o(sel), .addr_o(addr),
   .ad_i(ad_i), .ad_o(), .ad_oe_o());
  ext_mem_model ext_mem_model_inst
  (.clk_i(clk_i), .strobes_i(strobes_o), .addr_i(addr), .waits_i(waits),
   .ready_o(ready_i), .ad_o(ad_i));
  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : check
  task automatic test_done;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  // strobe history per access; strobes low outside an access are faults
  always @(negedge clk_i)
  begin
    cyc <= cyc + 1;
    seen <= seen | {(|lo) && sel !== ~(4'h1 << req_i.space),
      strobes_o.ale, !ube, lo};
    if (!act) check(lo === 3'b000, "idle strobe");
    if (cyc == 20000)
    begin
      failures++;
      test_done;
    end
  end
  // one access, bounded waits on the handshake and the completion pulse
  task automatic access(input logic wr, input logic [3:0] w);
    req_i = {wr, 20'($urandom), 2'($urandom), 16'($urandom)};
    waits = w;
    seen = 0;
    req_valid_i = 1;
    act = 1;
    for (lat = 0; lat < 200 && req_ready_o !== 1'b1; lat++) @(negedge clk_i);
    req_valid_i = 0;
    for (lat = 0; lat < 200 && done_o !== 1'b1; lat++) @(negedge clk_i);
    check(done_o === 1'b1, "no done");
    if (!wr && !width_strap_i)
      check(rdata_o === (req_i.addr[15:0] ^ 16'h5A5A), "rdata");
    check(seen[2] === !wr && seen[4] && !seen[5], "rd ale sel");
    if (wr && !scheme_i)
      check(seen[1:0] === (req_i.addr[0] ? 2'b01 : 2'b10), "split");
    if (wr && scheme_i)
      check(seen[3] === req_i.addr[0] && seen[1], "combined");
    @(negedge clk_i);
    act = 0;
  endtask : access
  initial
  begin
    void'($urandom(32'h324d4c3c));
    for (int m = 0; m < 2; m++)
    begin
      nrst_i = 0;
      scheme_i = m[0];
      width_strap_i = m[0];
      repeat (12) @(negedge clk_i);
      nrst_i = 1;
      for (int i = 0; i < 24; i++) access(i[0], 4'(i % 3));
    end
    access(0, 0);
    lat0 = lat;
    access(0, 6);
    check(lat > lat0 + 3, "wait ignored");
    bus_request_n_i = 0;
    repeat (4) @(negedge clk_i);
    repeat (6) @(negedge clk_i) check(bus_grant_n_o === 1'b0, "grant");
    bus_request_n_i = 1;
    repeat (6) @(negedge clk_i);
    check(bus_grant_n_o === 1'b1, "release");
    access(1, 0);
    test_done;
  end
endmodule : external_bus_strobe_control_tb_top
